/* rtl/srl_top.sv */
// Purpose: set-reset latch unit with selectable sources and pin outputs
// Assumes: 100 MHz clk; comparator and latch input pin are asynchronous;
//    timer_tick is a one-cycle enable from the sixteen-bit timer, same clock
// Notes: the latch state is a flip-flop with no reset, so it stays unknown
//    until software or a source sets or resets it
// Function
// - Latch holds state between events; every set and reset source is active high.
// - Any enabled reset with any enabled set high: latch goes and stays reset.
// - Software set and reset bits clear themselves; one write completes the action.
// - Comparator one output can set and reset the latch through own enables.
// - Comparator output may be synchronised to the timer clock before use.
// - Latch input pin level can set and reset through separate enables.
// - Periodic pulse sets or resets the latch through two independent enables.
// - Divider select code 0 gives period 4, each code doubles, 7 gives 512.
// - True and inverted outputs have own enables and may drive together.
// - Device reset leaves latch state undefined; no value forced on it.
// - Each divider pulse is high exactly one clock per selected period.
// - Writing one drives the latch input one clock; bit always reads zero.
// - Unit enable gates only the pin outputs, not the latch; when clear, output enables do nothing.
// - Pin set enable sets while pin high; pin reset enable resets likewise.
`timescale 1ns/10ps
`include "srl_params.svh"
module srl_top (
   // Clock, clock enable and reset
   input logic clk,
   input logic ce,
   input logic rst_n,
   // Avalon-MM slave
   input srl_pkg::srl_addr_t avs_address,
   input logic avs_read,
   input logic avs_write,
   input srl_pkg::srl_word_t avs_writedata,
   input srl_pkg::srl_be_t avs_byteenable,
   output srl_pkg::srl_word_t avs_readdata,
   output logic avs_waitrequest,
   // Latch sources
   input logic comparator_one_output,
   input logic latch_input_pin,
   input logic timer_tick,
   // Latch output pins
   output logic q_pin_out,
   output logic q_pin_oe,
   output logic nq_pin_out,
   output logic nq_pin_oe
);
   import srl_pkg::*;

   // Reset release chain
   logic rst_meta_n;
   logic rst_sync_n;

   // Registers
   srl_ctrl0_s ctrl0;
   srl_ctrl1_s ctrl1;
   logic comparator_sync_select;
   logic soft_set_pulse;
   logic soft_reset_pulse;

   // Bus handshake
   logic wait_q;
   srl_word_t rdata_q;

   // Source synchronisers
   logic cmp_meta;
   logic cmp_sync;
   logic cmp_timed;
   logic pin_meta;
   logic pin_sync;

   // Latch and outputs
   logic latch_q;
   logic q_out_q;
   logic q_oe_q;
   logic nq_out_q;
   logic nq_oe_q;

   // Divider link
   srl_div_if dif ();

   // Reset: asynchronous assert, released through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Bus decode
   logic req;
   logic take;
   logic lane0;
   logic wr_take;
   logic hit_c0;
   logic hit_c1;
   logic hit_cfg;
   logic hit_st;
   logic wr_c0;
   logic wr_c1;
   logic wr_cfg;
   logic rd_take;
   logic next_wait;

   assign req = avs_read | avs_write;
   assign take = req & ~wait_q;
   assign lane0 = avs_byteenable[`SRL_LANE0];
   assign wr_take = take & avs_write & lane0;
   assign hit_c0 = (avs_address == `SRL_OFF_CTRL0);
   assign hit_c1 = (avs_address == `SRL_OFF_CTRL1);
   assign hit_cfg = (avs_address == `SRL_OFF_CONFIG);
   assign hit_st = (avs_address == `SRL_OFF_STATUS);
   assign wr_c0 = wr_take & hit_c0;
   assign wr_c1 = wr_take & hit_c1;
   assign wr_cfg = wr_take & hit_cfg;
   assign rd_take = avs_read & wait_q;
   assign next_wait = ~(req & wait_q);

   // Write data fields in the low byte
   srl_ctrl0_s wd_c0;
   srl_ctrl1_s wd_c1;
   logic wd_ps;
   logic wd_pr;
   logic wd_cfg;

   assign wd_c0 = avs_writedata[7:2];
   assign wd_ps = avs_writedata[1];
   assign wd_pr = avs_writedata[0];
   assign wd_c1 = {avs_writedata[7:6], avs_writedata[4:2], avs_writedata[0]};
   assign wd_cfg = avs_writedata[0];

   // Read mux; pulse bits and reserved bits read zero
   srl_word_t rd_c0;
   srl_word_t rd_c1;
   srl_word_t rd_cfg;
   srl_word_t rd_st;
   srl_word_t rd_mux;

   assign rd_c0 = {`SRL_PAD24, ctrl0, 1'b0, 1'b0};
   assign rd_c1 = {`SRL_PAD24, ctrl1.pin_set_enable, ctrl1.pulse_set_enable, 1'b0,
                   ctrl1.comparator_set_enable, ctrl1.pin_reset_enable,
                   ctrl1.pulse_reset_enable, 1'b0, ctrl1.comparator_reset_enable};
   assign rd_cfg = {`SRL_PAD31, comparator_sync_select};
   assign rd_st = {`SRL_PAD28, pin_sync, cmp_timed, dif.pulse, latch_q};
   assign rd_mux = hit_c0 ? rd_c0 :
                   hit_c1 ? rd_c1 :
                   hit_cfg ? rd_cfg :
                   hit_st ? rd_st : `SRL_WORD_ZERO;

   // Waitrequest drops for one cycle after a request is seen
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wait_q <= 1'b1;
         rdata_q <= `SRL_WORD_ZERO;
      end else if (ce) begin
         wait_q <= next_wait;
         if (rd_take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   // Stored control registers; writes land on the accepting edge
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl0 <= `SRL_CTRL0_RST;
         ctrl1 <= `SRL_CTRL1_RST;
         comparator_sync_select <= `SRL_CONFIG_RST;
      end else if (ce) begin
         if (wr_c0) begin
            ctrl0 <= wd_c0;
         end
         if (wr_c1) begin
            ctrl1 <= wd_c1;
         end
         if (wr_cfg) begin
            comparator_sync_select <= wd_cfg;
         end
      end
   end

   // Software pulses live one clock and clear themselves
   logic next_soft_set;
   logic next_soft_reset;
   assign next_soft_set = wr_c0 & wd_ps;
   assign next_soft_reset = wr_c0 & wd_pr;

   // Pulse bits are held here for one clock but never read back, so a read can only show zero
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         soft_set_pulse <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else if (ce) begin
         soft_set_pulse <= next_soft_set;
         soft_reset_pulse <= next_soft_reset;
      end
   end

   // Two-stage synchronisers for the asynchronous sources
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else if (ce) begin
         cmp_meta <= comparator_one_output;
         cmp_sync <= cmp_meta;
         pin_meta <= latch_input_pin;
         pin_sync <= pin_meta;
      end
   end

   // Optional retiming of the comparator to the timer clock ticks
   logic cmp_take;
   assign cmp_take = ~comparator_sync_select | timer_tick;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmp_timed <= 1'b0;
      end else if (ce) begin
         if (cmp_take) begin
            cmp_timed <= cmp_sync;
         end
      end
   end

   // Divider: select goes out, one-clock pulse comes back
   assign dif.sel = ctrl0.latch_pulse_divider_select;

   srl_pulse_div u_div (
      .clk(clk),
      .ce(ce),
      .rst_sync_n(rst_sync_n),
      .dif(dif)
   );

   // Gathered set and reset requests, each source but the software pulses behind its own enable
   logic set_cmp;
   logic set_pin;
   logic set_clk;
   logic rst_cmp;
   logic rst_pin;
   logic rst_clk;
   logic set_any;
   logic reset_any;

   assign set_cmp = ctrl1.comparator_set_enable & cmp_timed;
   assign rst_cmp = ctrl1.comparator_reset_enable & cmp_timed;
   assign set_pin = ctrl1.pin_set_enable & pin_sync;
   assign rst_pin = ctrl1.pin_reset_enable & pin_sync;
   assign set_clk = ctrl1.pulse_set_enable & dif.pulse;
   assign rst_clk = ctrl1.pulse_reset_enable & dif.pulse;
   assign set_any = soft_set_pulse | set_cmp | set_pin | set_clk;
   assign reset_any = soft_reset_pulse | rst_cmp | rst_pin | rst_clk;

   // Reset-dominant next state of the latch
   logic next_latch;
   assign next_latch = reset_any ? 1'b0 : (set_any ? 1'b1 : latch_q);

   // Latch state has no reset by design, so it powers up unknown
   always_ff @(posedge clk) begin
      if (ce) begin
         latch_q <= next_latch;
      end
   end

   // Output gating: unit enable overrides both output enables
   logic next_q_oe;
   logic next_nq_oe;
   assign next_q_oe = ctrl0.latch_unit_enable & ctrl0.true_output_enable;
   assign next_nq_oe = ctrl0.latch_unit_enable & ctrl0.inverted_output_enable;
   logic next_q_out;
   logic next_nq_out;
   assign next_q_out = next_q_oe & latch_q;
   assign next_nq_out = next_nq_oe & ~latch_q;

   // Pin drivers; value forced low while its enable is off
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q_out_q <= 1'b0;
         q_oe_q <= 1'b0;
         nq_out_q <= 1'b0;
         nq_oe_q <= 1'b0;
      end else if (ce) begin
         q_oe_q <= next_q_oe;
         nq_oe_q <= next_nq_oe;
         q_out_q <= next_q_out;
         nq_out_q <= next_nq_out;
      end
   end

   assign q_pin_out = q_out_q;
   assign q_pin_oe = q_oe_q;
   assign nq_pin_out = nq_out_q;
   assign nq_pin_oe = nq_oe_q;
endmodule

/* pkg/srl_params.svh */
// Purpose: named constants of the set-reset latch unit
// Assumes: included by its bare name from the design files
// Notes: definitions only
`ifndef SRL_PARAMS_SVH
`define SRL_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define SRL_OFF_CTRL0 4'h0
`define SRL_OFF_CTRL1 4'h4
`define SRL_OFF_CONFIG 4'h8
`define SRL_OFF_STATUS 4'hc

// Reset values of the stored control registers
`define SRL_CTRL0_RST 6'h00
`define SRL_CTRL1_RST 6'h00
`define SRL_CONFIG_RST 1'h0

// Padding of 8-, 4- and 1-bit read values up to the 32-bit data bus
`define SRL_PAD24 24'h000000
`define SRL_PAD28 28'h0000000
`define SRL_PAD31 31'h00000000
`define SRL_WORD_ZERO 32'h00000000

// Byte lane that carries every register
`define SRL_LANE0 0

// Divider: 9-bit counter, period 4 << select
`define SRL_DIV_ALL 9'h1ff
`define SRL_DIV_ZERO 9'h000
`define SRL_DIV_ONE 9'h001
`define SRL_DIV_SEL_MAX 3'h7
`define SRL_DIV_SEL_RST 3'h0

`endif

/* pkg/srl_pkg.sv */
// Purpose: types shared by the set-reset latch unit files
// Assumes: constants live in srl_params.svh
// Notes: field layouts follow the control register bit order
package srl_pkg;

   typedef logic [3:0] srl_addr_t;
   typedef logic [31:0] srl_word_t;
   typedef logic [3:0] srl_be_t;
   typedef logic [2:0] srl_div_sel_t;
   typedef logic [8:0] srl_div_cnt_t;

   // latch_control_zero, stored part (bits 7..2; bits 1..0 are pulses)
   typedef struct packed {
      logic latch_unit_enable;
      srl_div_sel_t latch_pulse_divider_select;
      logic true_output_enable;
      logic inverted_output_enable;
   } srl_ctrl0_s;

   // latch_control_one, stored part (reserved bits 5 and 1 dropped)
   typedef struct packed {
      logic pin_set_enable;
      logic pulse_set_enable;
      logic comparator_set_enable;
      logic pin_reset_enable;
      logic pulse_reset_enable;
      logic comparator_reset_enable;
   } srl_ctrl1_s;

endpackage

/* pkg/srl_div_if.sv */
// Purpose: carries divider select out and periodic pulse back
// Assumes: one clock domain
// Notes: ctrl side is the latch core, div side the pulse divider
`timescale 1ns/10ps
interface srl_div_if;
   srl_pkg::srl_div_sel_t sel;
   logic pulse;

   modport ctrl (output sel, input pulse);
   modport div (input sel, output pulse);
endinterface

/* rtl/srl_pulse_div.sv */
// Purpose: periodic one-cycle pulse from a free-running divider
// Assumes: ce freezes the counter; rst_sync_n is already synchronised
// Notes: select is taken only at the full counter wrap
`timescale 1ns/10ps
`include "srl_params.svh"
module srl_pulse_div (
   // Clock, enable and reset
   input logic clk,
   input logic ce,
   input logic rst_sync_n,
   // Select in, pulse out
   srl_div_if.div dif
);
   import srl_pkg::*;

   srl_div_cnt_t cnt;
   srl_div_sel_t sel_held;
   logic pulse_q;
   srl_div_cnt_t low_mask;
   logic wrap;
   logic hit;

   // Period is 4 << select: low select+2 bits all ones marks the end
   assign low_mask = `SRL_DIV_ALL >> (`SRL_DIV_SEL_MAX - sel_held);
   assign hit = &(cnt | ~low_mask);
   assign wrap = (cnt == `SRL_DIV_ALL);
   assign dif.pulse = pulse_q;

   // Counter stops only while ce is low; retiming the select at wrap avoids short periods
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cnt <= `SRL_DIV_ZERO;
         sel_held <= `SRL_DIV_SEL_RST;
         pulse_q <= 1'b0;
      end else if (ce) begin
         cnt <= cnt + `SRL_DIV_ONE;
         if (wrap) begin
            sel_held <= dif.sel;
         end
         pulse_q <= hit;
      end
   end
endmodule

/* verif/srl_top_chk.sv */
// Purpose: port-level checks of srl_top
// Assumes: ce high means run; latch made known before both pins drive
// Notes: bound onto every srl_top instance
`timescale 1ns/10ps
module srl_top_chk (
   // Clock and reset
   input logic clk,
   input logic ce,
   input logic rst_n,
   // Bus
   input srl_pkg::srl_addr_t avs_address,
   input logic avs_read,
   input logic avs_write,
   input srl_pkg::srl_word_t avs_writedata,
   input srl_pkg::srl_be_t avs_byteenable,
   input srl_pkg::srl_word_t avs_readdata,
   input logic avs_waitrequest,
   // Pins
   input logic q_pin_out,
   input logic q_pin_oe,
   input logic nq_pin_out,
   input logic nq_pin_oe
);
   import srl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Completed write to control zero low byte
   wire wr0 = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
   q_gate_a: assert property (q_pin_out |-> q_pin_oe)
      else $error("true pin high while not driven");
   nq_gate_a: assert property (nq_pin_out |-> nq_pin_oe)
      else $error("inverted pin high while not driven");
   // Settled one cycle so an output register lagging its enable is not flagged
   out_compl_a: assert property (q_pin_oe && nq_pin_oe && $past(q_pin_oe) && $past(nq_pin_oe) |-> q_pin_out != nq_pin_out)
      else $error("pins not complementary");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low over one cycle");
   take_req_a: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered next cycle");
   pulse_rd0_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[1:0] == 2'b00)
      else $error("pulse bits read nonzero");
   unit_off_a: assert property (wr0 && !avs_writedata[7] |-> ##2 !q_pin_oe && !nq_pin_oe)
      else $error("pins driven with unit off");
   soft_rst_a: assert property (wr0 && avs_writedata[0] |-> ##3 !q_pin_out)
      else $error("soft reset did not clear pin");
   cover property (wr0 && avs_writedata[1]);
   cover property (q_pin_oe && nq_pin_oe && q_pin_out);
   cover property (avs_read && !avs_waitrequest);
endmodule

bind srl_top srl_top_chk chk (.clk(clk), .ce(ce), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .q_pin_out(q_pin_out), .q_pin_oe(q_pin_oe),
   .nq_pin_out(nq_pin_out), .nq_pin_oe(nq_pin_oe));

/* verif/srl_far_model.sv */
// Purpose: comparator, latch input pin and timer tick seen by the unit
// Assumes: levels asked by the bench appear one edge later
// Notes: tick every third cycle so retiming adds a real wait
`timescale 1ns/10ps
module srl_far_model (
   // Clock and requests
   input logic clk,
   input logic cmp_want,
   input logic pin_want,
   // Source outputs
   output logic comparator_one_output,
   output logic latch_input_pin,
   output logic timer_tick
);
   logic [1:0] tcnt = 2'h0;
   // Active-high levels, tick from the sixteen-bit timer
   always @(posedge clk) begin
      comparator_one_output <= cmp_want;
      latch_input_pin <= pin_want;
      tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
      timer_tick <= (tcnt == 2'h0);
   end
endmodule

/* verif/set_reset_latch_unit_bench.sv */
// Purpose: self-checking bench of srl_top
// Assumes: ce held high except during the clock enable freeze check
// Notes: divider code 0 is not timed; a pin reset needs over 4 cycles
`timescale 1ns/10ps
module set_reset_latch_unit_bench;
   import srl_pkg::*;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic rst_n = 1'b0;
   srl_addr_t avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   srl_word_t avs_writedata = 32'h0;
   srl_be_t avs_byteenable = 4'hf;
   srl_word_t avs_readdata;
   logic avs_waitrequest, cmp, pin, tick_w, q_pin_out, q_pin_oe, nq_pin_out, nq_pin_oe;
   logic cmp_want = 1'b0;
   logic pin_want = 1'b0;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   srl_top dut (.clk(clk), .ce(ce), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .comparator_one_output(cmp),
      .latch_input_pin(pin), .timer_tick(tick_w), .q_pin_out(q_pin_out),
      .q_pin_oe(q_pin_oe), .nq_pin_out(nq_pin_out), .nq_pin_oe(nq_pin_oe));
   srl_far_model far (.clk(clk), .cmp_want(cmp_want), .pin_want(pin_want),
      .comparator_one_output(cmp), .latch_input_pin(pin), .timer_tick(tick_w));
   // Clock
   initial forever #5 clk = ~clk;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input srl_addr_t a, input logic [7:0] d,
      output srl_word_t r);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input srl_addr_t a, input logic [7:0] d);
      srl_word_t r;
      bus(1'b1, a, d, r);
   endtask
   function automatic logic exp_q(logic prev, logic [7:0] c1, logic p, logic c);
      logic s;
      logic r;
      s = (p & c1[7]) | (c & c1[4]);
      r = (p & c1[3]) | (c & c1[0]);
      return r ? 1'b0 : (s | prev);
   endfunction
   // Main sequence
   initial begin
      srl_word_t r;
      srl_addr_t ra[4];
      logic [7:0] c1;
      logic b;
      logic pq;
      logic rise;
      int t;
      int n;
      ra = '{4'h0, 4'h4, 4'h8, 4'h2};
      void'($urandom(40819));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, ra[i], 8'h00, r);
         chk(r, 32'h0);
      end
      wr(4'h0, 8'h0e);
      repeat (4) @(posedge clk);
      chk({q_pin_oe, nq_pin_oe}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 8'h8c + 8'(i));
         repeat (4) @(posedge clk);
         chk({q_pin_out, nq_pin_out}, {30'h0, !i[0], i[0]});
      end
      avs_byteenable <= 4'he;
      wr(4'h0, 8'h00);
      avs_byteenable <= 4'hf;
      bus(1'b0, 4'h0, 8'h00, r);
      chk(r, 32'h8c);
      chk({q_pin_oe, nq_pin_oe}, 32'h3);
      // Clock enable low must freeze the latch against a live pin set
      wr(4'h4, 8'h80);
      ce <= 1'b0;
      pin_want <= 1'b1;
      repeat (8) @(posedge clk);
      chk(q_pin_out, 32'h0);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      chk(q_pin_out, 32'h1);
      // Random level sources over a known start
      repeat (40) begin
         b = 1'($urandom);
         c1 = 8'($urandom) & 8'h99;
         wr(4'h4, 8'h00);
         wr(4'h8, 8'($urandom) & 8'h01);
         wr(4'h0, 8'h8d + 8'(b));
         cmp_want <= 1'($urandom);
         pin_want <= 1'($urandom);
         repeat (8) @(posedge clk);
         wr(4'h4, c1);
         repeat (12) @(posedge clk);
         chk(q_pin_out, exp_q(b, c1, pin_want, cmp_want));
      end
      // Divider pulses set, a one-cycle pin pulse resets after each rise
      for (int s = 1; s < 8; s++) begin
         // Pin left high by the last rise would hold the latch in reset
         pin_want <= 1'b0;
         wr(4'h4, 8'h00);
         wr(4'h0, 8'h89 | 8'(s << 4));
         // New select is adopted only at the full counter wrap
         repeat (520) @(posedge clk);
         wr(4'h4, 8'h48);
         n = 0;
         t = 0;
         pq = 1'b1;
         while (n < 3) begin
            @(posedge clk);
            t++;
            rise = q_pin_out === 1'b1 && pq === 1'b0;
            pin_want <= rise;
            pq = q_pin_out;
            if (rise) begin
               n++;
               if (n == 3) chk(t, 4 << s);
               t = 0;
            end
         end
      end
      end_sim();
   end
endmodule
